// ===== rtl/spmh_pkg.sv
package spmh_pkg;

  // ****************************************
  // Message layout
  // ****************************************
  localparam logic [7:0]  MSG_TYPE1        = 8'h01;
  localparam logic [7:0]  MSG_TYPE2        = 8'h02;
  localparam logic [7:0]  OP_SEG_LAUNCH    = 8'h78;
  localparam logic [7:0]  OP_PROG_HALT     = 8'h98;
  localparam logic [7:0]  OP_PARAM_WRITE   = 8'h83;
  localparam logic [7:0]  OP_PARAM_READ    = 8'h84;
  localparam logic [7:0]  OP_UREG_READ     = 8'h9A;
  localparam logic [7:0]  OP_PREG_WRITE    = 8'h9E;
  localparam logic [7:0]  OP_BUF_LOAD      = 8'h9F;
  localparam logic [7:0]  OP_BUF_SAVE      = 8'hA0;
  localparam logic [7:0]  OP_MAINT_PORT    = 8'hFF;
  localparam logic [7:0]  OPR_VELOCITY     = 8'h1D;
  localparam logic [7:0]  OPR_STATUS_WORD  = 8'h80;
  localparam logic [7:0]  OPR_PORT_RESET   = 8'h01;
  localparam logic [7:0]  OPR_PORT_OPEN    = 8'h00;
  localparam logic [7:0]  OPR_DECEL_QUICK  = 8'h00;
  localparam logic [7:0]  OPR_JOG_SPEED    = 8'h4A;

  // ****************************************
  // Sizes and codes
  // ****************************************
  localparam int          SEG_COUNT        = 12;
  localparam int          UREG_COUNT       = 10;
  localparam int          BUF_DEPTH        = 16;
  localparam logic [3:0]  SEG_MAX          = 4'hC;
  localparam logic [3:0]  UREG_MAX         = 4'h9;
  localparam logic [4:0]  BUF_LAST         = 5'h10;
  localparam logic [15:0] STAT_OK          = 16'h0000;
  localparam logic [15:0] STAT_BAD_REQ     = 16'h0008;
  localparam logic [15:0] STAT_BUSY        = 16'h000C;
  localparam logic [15:0] STAT_CONFLICT    = 16'h0010;
  localparam int          STATUS_RUN_BIT   = 14;
  localparam logic [15:0] ZERO16           = 16'h0000;

  typedef enum logic [1:0] {
    SPMH_IDLE = 2'b00,
    SPMH_RUN  = 2'b01,
    SPMH_LOAD = 2'b10
  } spmh_mode_e;

  typedef enum logic [1:0] {
    SPMH_PORT_OPEN  = 2'b00,
    SPMH_PORT_HELD  = 2'b01,
    SPMH_PORT_CLOSE = 2'b10
  } spmh_port_e;

  // Eight-byte payload, byte 0 in [7:0]
  typedef struct packed {
    logic [7:0] b7;
    logic [7:0] b6;
    logic [7:0] b5;
    logic [7:0] b4;
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } spmh_msg_s;

  // Instruction handed to the sequencer
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  operand;
  } spmh_instr_s;

endpackage

// ===== rtl/spmh_port_guard.sv
// Maintenance port ownership: one host until explicitly released
module spmh_port_guard (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        connect_req,
  input  wire logic        reset_cmd,
  input  wire logic        open_cmd,
  output logic             port_held,
  output logic             port_closed
);

  spmh_pkg::spmh_port_e state_reg;
  spmh_pkg::spmh_port_e state_next;

  // ****************************************
  // Port state
  // ****************************************
  // Close beats connect in one cycle; host must reopen explicitly
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      spmh_pkg::SPMH_PORT_OPEN:
      begin
        if (reset_cmd)
          state_next = spmh_pkg::SPMH_PORT_CLOSE;
        else if (connect_req)
          state_next = spmh_pkg::SPMH_PORT_HELD;
      end
      spmh_pkg::SPMH_PORT_HELD:
      begin
        if (reset_cmd)
          state_next = spmh_pkg::SPMH_PORT_CLOSE;
      end
      spmh_pkg::SPMH_PORT_CLOSE:
      begin
        if (open_cmd)
          state_next = spmh_pkg::SPMH_PORT_OPEN;
      end
      default: state_next = spmh_pkg::SPMH_PORT_OPEN;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_reg <= spmh_pkg::SPMH_PORT_OPEN;
    else
      state_reg <= state_next;
  end

  assign port_held   = (state_reg == spmh_pkg::SPMH_PORT_HELD);
  assign port_closed = (state_reg == spmh_pkg::SPMH_PORT_CLOSE);

  property p_held_until_reset;
    @(posedge ref_clk) disable iff (rst)
    port_held && !reset_cmd |=> port_held;
  endproperty
  a_held_until_reset: assert property (p_held_until_reset) else $error("host lost without reset");

  property p_reset_closes;
    @(posedge ref_clk) disable iff (rst)
    reset_cmd && !port_closed |=> port_closed;
  endproperty
  a_reset_closes: assert property (p_reset_closes) else $error("port reset did not close");

  property p_open_reopens;
    @(posedge ref_clk) disable iff (rst)
    port_closed && open_cmd |=> !port_closed && !port_held;
  endproperty
  a_open_reopens: assert property (p_open_reopens) else $error("port not reopened");

  c_reset_then_open: cover property (@(posedge ref_clk) reset_cmd ##[1:20] open_cmd);

endmodule // spmh_port_guard

// ===== rtl/spmh_seq.sv
// Segment sequencer: steps through stored instructions
module spmh_seq (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  input  wire logic [3:0]           start_seg,
  input  wire logic                 halt,
  input  wire spmh_pkg::spmh_instr_s cur_instr,
  input  wire logic                 instr_blank,
  output logic                      running,
  output logic [3:0]                seg,
  output logic [3:0]                line
);

  logic       run_reg;
  logic       run_next;
  logic [3:0] seg_reg;
  logic [3:0] seg_next;
  logic [3:0] line_reg;
  logic [3:0] line_next;

  // ****************************************
  // Execution step
  // ****************************************
  // One instruction per cycle; a launch opcode inside a segment is a jump with no return
  always_comb
  begin
    run_next  = run_reg;
    seg_next  = seg_reg;
    line_next = line_reg;
    if (halt)
      run_next = 1'b0;
    else if (start)
    begin
      run_next  = 1'b1;
      seg_next  = start_seg;
      line_next = 4'h0;
    end
    else if (run_reg)
    begin
      if (instr_blank)
        run_next = 1'b0;
      // Same segment range as a host launch, so a stray high nibble never aliases
      else if (cur_instr.opcode == spmh_pkg::OP_SEG_LAUNCH &&
               cur_instr.operand[7:4] == 4'h0 &&
               cur_instr.operand[3:0] != 4'h0 &&
               cur_instr.operand[3:0] <= spmh_pkg::SEG_MAX)
      begin
        seg_next  = cur_instr.operand[3:0] - 4'h1;
        line_next = 4'h0;
      end
      else
        line_next = line_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      run_reg  <= 1'b0;
      seg_reg  <= 4'h0;
      line_reg <= 4'h0;
    end
    else
    begin
      run_reg  <= run_next;
      seg_reg  <= seg_next;
      line_reg <= line_next;
    end
  end

  assign running = run_reg;
  assign seg     = seg_reg;
  assign line    = line_reg;

  property p_blank_ends;
    @(posedge ref_clk) disable iff (rst)
    run_reg && instr_blank && !start |=> !run_reg;
  endproperty
  a_blank_ends: assert property (p_blank_ends) else $error("blank line did not end run");

  c_self_stop: cover property (@(posedge ref_clk) start ##[1:40] (run_reg && instr_blank));

endmodule // spmh_seq

// ===== rtl/spmh_handler.sv
module spmh_handler (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  req_valid,
  input  wire spmh_pkg::spmh_msg_s   req_msg,
  input  wire logic                  host_connect,
  input  wire logic                  move_start,
  input  wire logic [15:0]           drive_status,
  output logic                       rsp_valid,
  output spmh_pkg::spmh_msg_s        rsp_msg,
  output logic                       halt_pulse,
  output logic                       halt_quick,
  output logic [15:0]                velocity_param,
  output logic [15:0]                jog_speed,
  output logic                       prog_running,
  output logic                       maint_port_held,
  output logic                       maint_port_closed
);

  // ****************************************
  // State
  // ****************************************
  spmh_pkg::spmh_instr_s seg_mem_reg  [spmh_pkg::SEG_COUNT][spmh_pkg::BUF_DEPTH];
  spmh_pkg::spmh_instr_s seg_mem_next [spmh_pkg::SEG_COUNT][spmh_pkg::BUF_DEPTH];
  spmh_pkg::spmh_instr_s buf_reg      [spmh_pkg::BUF_DEPTH];
  spmh_pkg::spmh_instr_s buf_next     [spmh_pkg::BUF_DEPTH];
  logic [4:0]            buf_cnt_reg;
  logic [4:0]            buf_cnt_next;
  logic                  loading_reg;
  logic                  loading_next;
  logic [15:0]           ureg_reg     [spmh_pkg::UREG_COUNT];
  logic [15:0]           ureg_next    [spmh_pkg::UREG_COUNT];
  logic [15:0]           vel_pend_reg;
  logic [15:0]           vel_pend_next;
  logic [15:0]           vel_reg;
  logic [15:0]           vel_next;
  logic [15:0]           jog_reg;
  logic [15:0]           jog_next;
  logic                  rsp_valid_reg;
  spmh_pkg::spmh_msg_s   rsp_msg_reg;
  spmh_pkg::spmh_msg_s   rsp_msg_next;
  logic                  halt_reg;
  logic                  halt_next;
  logic                  quick_reg;
  logic                  quick_next;
  logic                  held_reg;
  logic                  closed_reg;
  logic                  run_reg;

  logic                  seq_start;
  logic [3:0]            seq_start_seg;
  logic                  seq_running;
  logic [3:0]            seq_seg;
  logic [3:0]            seq_line;
  spmh_pkg::spmh_instr_s cur_instr;
  logic                  cur_blank;
  logic                  port_reset_cmd;
  logic                  port_open_cmd;
  logic                  port_held;
  logic                  port_closed;
  logic [15:0]           status_word;
  logic [15:0]           stat;
  logic                  is_t1;
  logic                  is_t2;

  // Segment number 1..12 is valid
  function automatic logic seg_ok(input logic [7:0] n);
    seg_ok = (n != 8'h00) && (n <= {4'h0, spmh_pkg::SEG_MAX});
  endfunction

  assign is_t1 = req_valid && (req_msg.b1 == spmh_pkg::MSG_TYPE1);
  assign is_t2 = req_valid && (req_msg.b1 == spmh_pkg::MSG_TYPE2);

  // Status word with the run flag forced in
  always_comb
  begin
    status_word = drive_status;
    status_word[spmh_pkg::STATUS_RUN_BIT] = seq_running;
  end

  assign cur_instr = seg_mem_reg[seq_seg][seq_line];
  assign cur_blank = (cur_instr.opcode == 8'h00);

  // ****************************************
  // Request decode and storage updates
  // ****************************************
  // Loading takes Type 1 ahead of execution; a busy sequencer refuses them
  always_comb
  begin
    seg_mem_next   = seg_mem_reg;
    buf_next       = buf_reg;
    buf_cnt_next   = buf_cnt_reg;
    loading_next   = loading_reg;
    ureg_next      = ureg_reg;
    vel_pend_next  = vel_pend_reg;
    vel_next       = move_start ? vel_pend_reg : vel_reg;
    jog_next       = jog_reg;
    halt_next      = 1'b0;
    quick_next     = quick_reg;
    seq_start      = 1'b0;
    seq_start_seg  = 4'h0;
    port_reset_cmd = 1'b0;
    port_open_cmd  = 1'b0;
    stat           = spmh_pkg::STAT_BAD_REQ;
    if (is_t1)
    begin
      if (seq_running)
        stat = spmh_pkg::STAT_BUSY;
      else if (loading_reg)
      begin
        if (buf_cnt_reg != spmh_pkg::BUF_LAST)
        begin
          buf_next[buf_cnt_reg[3:0]] = '{opcode: req_msg.b3, operand: req_msg.b7};
          buf_cnt_next = buf_cnt_reg + 5'h01;
          stat = spmh_pkg::STAT_OK;
        end
        else
          stat = spmh_pkg::STAT_CONFLICT;
      end
      else if (req_msg.b3 == spmh_pkg::OP_SEG_LAUNCH && seg_ok(req_msg.b7))
      begin
        seq_start     = 1'b1;
        seq_start_seg = req_msg.b7[3:0] - 4'h1;
        stat = spmh_pkg::STAT_OK;
      end
    end
    else if (is_t2)
    begin
      stat = spmh_pkg::STAT_OK;
      if (req_msg.b2 == spmh_pkg::OP_PROG_HALT)
      begin
        halt_next  = 1'b1;
        quick_next = (req_msg.b3 == spmh_pkg::OPR_DECEL_QUICK);
      end
      else if (req_msg.b2 == spmh_pkg::OP_UREG_READ && req_msg.b3[7:4] == 4'h0
               && req_msg.b3[3:0] <= spmh_pkg::UREG_MAX)
        stat = ureg_reg[req_msg.b3[3:0]];
      else if (req_msg.b2 == spmh_pkg::OP_PREG_WRITE && req_msg.b3[7:4] == 4'h0
               && req_msg.b3[3:0] <= spmh_pkg::UREG_MAX)
        ureg_next[req_msg.b3[3:0]] = {req_msg.b4, req_msg.b5};
      else if (req_msg.b2 == spmh_pkg::OP_PREG_WRITE && req_msg.b3 == spmh_pkg::OPR_JOG_SPEED)
        jog_next = {req_msg.b4, req_msg.b5};
      else if (req_msg.b2 == spmh_pkg::OP_PARAM_WRITE && req_msg.b3 == spmh_pkg::OPR_VELOCITY)
        vel_pend_next = {req_msg.b4, req_msg.b5};
      else if (req_msg.b2 == spmh_pkg::OP_PARAM_READ && req_msg.b3 == spmh_pkg::OPR_STATUS_WORD)
        stat = status_word;
      else if (req_msg.b2 == spmh_pkg::OP_BUF_LOAD && !seq_running)
      begin
        loading_next = 1'b1;
        buf_cnt_next = 5'h00;
      end
      else if (req_msg.b2 == spmh_pkg::OP_BUF_SAVE && loading_reg && seg_ok(req_msg.b3))
      begin
        for (int i = 0; i < spmh_pkg::BUF_DEPTH; i++)
          seg_mem_next[req_msg.b3[3:0] - 4'h1][i] =
            (5'(i) < buf_cnt_reg) ? buf_reg[i] : '0;
        loading_next = 1'b0;
      end
      else if (req_msg.b2 == spmh_pkg::OP_MAINT_PORT && req_msg.b3 == spmh_pkg::OPR_PORT_RESET)
        port_reset_cmd = 1'b1;
      else if (req_msg.b2 == spmh_pkg::OP_MAINT_PORT && req_msg.b3 == spmh_pkg::OPR_PORT_OPEN)
        port_open_cmd = 1'b1;
      else
        stat = spmh_pkg::STAT_BAD_REQ;
    end
    // Echo header, status big-endian, trailing bytes zero
    rsp_msg_next    = '0;
    rsp_msg_next.b1 = req_msg.b1;
    rsp_msg_next.b2 = req_msg.b2;
    rsp_msg_next.b3 = req_msg.b3;
    rsp_msg_next.b4 = stat[15:8];
    rsp_msg_next.b5 = stat[7:0];
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      seg_mem_reg   <= '{default: '{default: '0}};
      buf_reg       <= '{default: '0};
      buf_cnt_reg   <= 5'h00;
      loading_reg   <= 1'b0;
      ureg_reg      <= '{default: spmh_pkg::ZERO16};
      vel_pend_reg  <= spmh_pkg::ZERO16;
      vel_reg       <= spmh_pkg::ZERO16;
      jog_reg       <= spmh_pkg::ZERO16;
      rsp_valid_reg <= 1'b0;
      rsp_msg_reg   <= '0;
      halt_reg      <= 1'b0;
      quick_reg     <= 1'b0;
      held_reg      <= 1'b0;
      closed_reg    <= 1'b0;
      run_reg       <= 1'b0;
    end
    else
    begin
      seg_mem_reg   <= seg_mem_next;
      buf_reg       <= buf_next;
      buf_cnt_reg   <= buf_cnt_next;
      loading_reg   <= loading_next;
      ureg_reg      <= ureg_next;
      vel_pend_reg  <= vel_pend_next;
      vel_reg       <= vel_next;
      jog_reg       <= jog_next;
      rsp_valid_reg <= req_valid;
      rsp_msg_reg   <= rsp_msg_next;
      halt_reg      <= halt_next;
      quick_reg     <= quick_next;
      held_reg      <= port_held;
      closed_reg    <= port_closed;
      run_reg       <= seq_running;
    end
  end

  spmh_seq u_seq (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .start       (seq_start),
    .start_seg   (seq_start_seg),
    .halt        (halt_next),
    .cur_instr   (cur_instr),
    .instr_blank (cur_blank),
    .running     (seq_running),
    .seg         (seq_seg),
    .line        (seq_line)
  );

  spmh_port_guard u_port (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .connect_req (host_connect),
    .reset_cmd   (port_reset_cmd),
    .open_cmd    (port_open_cmd),
    .port_held   (port_held),
    .port_closed (port_closed)
  );

  assign rsp_valid         = rsp_valid_reg;
  assign rsp_msg           = rsp_msg_reg;
  assign halt_pulse        = halt_reg;
  assign halt_quick        = quick_reg;
  assign velocity_param    = vel_reg;
  assign jog_speed         = jog_reg;
  assign prog_running      = run_reg;
  assign maint_port_held   = held_reg;
  assign maint_port_closed = closed_reg;

  // ****************************************
  // Checks
  // ****************************************
  property p_t1_refused;
    @(posedge ref_clk) disable iff (rst)
    is_t1 && seq_running |=> rsp_msg.b4 == 8'h00 && rsp_msg.b5 == spmh_pkg::STAT_BUSY[7:0];
  endproperty
  a_t1_refused: assert property (p_t1_refused) else $error("busy type 1 not refused");

  property p_launch;
    @(posedge ref_clk) disable iff (rst)
    is_t1 && !seq_running && !loading_reg && req_msg.b3 == spmh_pkg::OP_SEG_LAUNCH
      && seg_ok(req_msg.b7) |=> ##1 prog_running;
  endproperty
  a_launch: assert property (p_launch) else $error("segment not launched");

  property p_halt;
    @(posedge ref_clk) disable iff (rst)
    is_t2 && req_msg.b2 == spmh_pkg::OP_PROG_HALT |=> halt_pulse ##1 !prog_running;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop program");

  property p_echo;
    @(posedge ref_clk) disable iff (rst)
    req_valid |=> rsp_valid && rsp_msg.b2 == $past(req_msg.b2) && rsp_msg.b6 == 8'h00 && rsp_msg.b7 == 8'h00;
  endproperty
  a_echo: assert property (p_echo) else $error("response header wrong");

  property p_vel_deferred;
    @(posedge ref_clk) disable iff (rst)
    !move_start |=> velocity_param == $past(velocity_param);
  endproperty
  a_vel_deferred: assert property (p_vel_deferred) else $error("velocity changed mid move");

  property p_status_bit;
    @(posedge ref_clk) disable iff (rst)
    is_t2 && req_msg.b2 == spmh_pkg::OP_PARAM_READ && req_msg.b3 == spmh_pkg::OPR_STATUS_WORD
      |=> rsp_msg.b4[6] == prog_running;
  endproperty
  a_status_bit: assert property (p_status_bit) else $error("run bit wrong");

  property p_unknown;
    @(posedge ref_clk) disable iff (rst)
    req_valid && !is_t1 && !is_t2 |=> {rsp_msg.b4, rsp_msg.b5} != spmh_pkg::STAT_OK;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown type accepted");

  c_launch_halt: cover property (@(posedge ref_clk) seq_start ##[1:30] halt_pulse);
  c_load_save: cover property (@(posedge ref_clk) loading_reg ##[1:50] !loading_reg);
  c_busy: cover property (@(posedge ref_clk) is_t1 && seq_running);

endmodule // spmh_handler

// ===== tb/spmh_host_model.sv
// ****************************************
// Network host sending explicit messages
// ****************************************
module spmh_host_model (
  input  wire logic                ref_clk,
  output logic                     req_valid,
  output spmh_pkg::spmh_msg_s      req_msg,
  input  wire logic                rsp_valid,
  input  wire spmh_pkg::spmh_msg_s rsp_msg
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet until the bench asks for traffic
  initial
  begin
    req_valid = 1'b0;
    req_msg   = '0;
  end

  // One request per call; the editing tool never shares the link
  task automatic send(input spmh_pkg::spmh_msg_s msg, output spmh_pkg::spmh_msg_s rsp, output logic got);
    @(posedge ref_clk);
    #1;
    req_valid = 1'b1;
    req_msg   = msg;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    req_msg   = ~msg; // Stale payload inverted so it cannot pass for valid
    got       = rsp_valid;
    rsp       = rsp_msg;
  endtask
endmodule // spmh_host_model

// ===== tb/test_spmh_handler.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end

module test_spmh_handler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  T1 = spmh_pkg::MSG_TYPE1;
  localparam logic [7:0]  T2 = spmh_pkg::MSG_TYPE2;
  localparam logic [15:0] OK = spmh_pkg::STAT_OK;
  localparam logic [15:0] Z  = 16'h0000;
  localparam logic [15:0] DS = 16'h0011;

  logic                ref_clk = 1'b0;
  logic                rst, req_valid, host_connect, move_start, rsp_valid;
  logic                halt_pulse, halt_quick, prog_running, held, closed;
  logic [15:0]         drive_status, velocity_param, jog_speed;
  spmh_pkg::spmh_msg_s req_msg, rsp_msg;
  int                  n_errors = 0, checked = 0, cyc = 0, n_halt = 0, i;

  // ****************************************
  // Clock, design and host
  // ****************************************
  always #10 ref_clk = ~ref_clk;

  spmh_handler DUT (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_msg(req_msg),
    .host_connect(host_connect), .move_start(move_start), .drive_status(drive_status),
    .rsp_valid(rsp_valid), .rsp_msg(rsp_msg), .halt_pulse(halt_pulse), .halt_quick(halt_quick),
    .velocity_param(velocity_param), .jog_speed(jog_speed), .prog_running(prog_running),
    .maint_port_held(held), .maint_port_closed(closed));

  spmh_host_model host (.ref_clk(ref_clk), .req_valid(req_valid), .req_msg(req_msg),
    .rsp_valid(rsp_valid), .rsp_msg(rsp_msg));

  // Halt pulses counted, cycle ceiling guards against a hang
  always @(posedge ref_clk)
  begin
    cyc++;
    if (halt_pulse === 1'b1) n_halt++;
    if (cyc == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One message and its reply; type 1 carries opcode in b3, operand in b7
  task automatic xfer(input logic [7:0] typ, op, opr, input logic [15:0] val, exp);
    spmh_pkg::spmh_msg_s m, r, e;
    logic                got;
    m = '0;
    m.b1 = typ;
    {m.b4, m.b5} = val;
    if (typ == T1) {m.b3, m.b7} = {op, opr};
    else {m.b2, m.b3} = {op, opr};
    e = '0;
    {e.b1, e.b2, e.b3} = {m.b1, m.b2, m.b3};
    {e.b4, e.b5} = exp;
    host.send(m, r, got);
    `CHK(got, 1'b1)
    `CHK(r, e)
  endtask

  // Pulse move_start or host_connect, then let the levels settle
  task automatic pulse(input logic mv);
    @(posedge ref_clk);
    #1;
    if (mv) move_start = 1'b1;
    else host_connect = 1'b1;
    @(posedge ref_clk);
    #1;
    move_start = 1'b0;
    host_connect = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    host_connect = 1'b0;
    move_start = 1'b0;
    drive_status = DS;
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    `CHK(prog_running, 1'b0)
    // Segment 1 filled to the brim, one step too many
    xfer(T2, spmh_pkg::OP_BUF_LOAD, 8'h00, Z, OK);
    for (i = 0; i < 16; i++) xfer(T1, 8'h20 + i[7:0], 8'h01, Z, OK);
    xfer(T1, 8'h40, 8'h02, Z, spmh_pkg::STAT_CONFLICT);
    xfer(T2, spmh_pkg::OP_BUF_SAVE, 8'h01, Z, OK);
    // Segment 2 holds one step, so it stops on its own
    xfer(T2, spmh_pkg::OP_BUF_LOAD, 8'h00, Z, OK);
    xfer(T1, 8'h31, 8'h05, Z, OK);
    xfer(T2, spmh_pkg::OP_BUF_SAVE, 8'h02, Z, OK);
    // Run, poll, retune jog, quick halt
    xfer(T1, spmh_pkg::OP_SEG_LAUNCH, 8'h01, Z, OK);
    xfer(T2, spmh_pkg::OP_PARAM_READ, spmh_pkg::OPR_STATUS_WORD, Z, DS | 16'h4000);
    xfer(T2, spmh_pkg::OP_PREG_WRITE, spmh_pkg::OPR_JOG_SPEED, 16'hFFFF, OK);
    `CHK(jog_speed, 16'hFFFF)
    xfer(T2, spmh_pkg::OP_PROG_HALT, 8'h00, Z, OK);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(prog_running, 1'b0)
    `CHK(halt_quick, 1'b1)
    `CHK(n_halt, 1)
    // Second run: refusal and user registers, normal halt
    xfer(T1, spmh_pkg::OP_SEG_LAUNCH, 8'h01, Z, OK);
    xfer(T1, 8'h20, 8'h00, Z, spmh_pkg::STAT_BUSY);
    xfer(T2, spmh_pkg::OP_PREG_WRITE, 8'h09, 16'hBEEF, OK);
    xfer(T2, spmh_pkg::OP_UREG_READ, 8'h09, Z, 16'hBEEF);
    xfer(T2, spmh_pkg::OP_PROG_HALT, 8'h01, Z, OK);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(halt_quick, 1'b0)
    `CHK(n_halt, 2)
    // Segment 3 only jumps to segment 1, so it keeps running until halted
    xfer(T2, spmh_pkg::OP_BUF_LOAD, 8'h00, Z, OK);
    xfer(T1, spmh_pkg::OP_SEG_LAUNCH, 8'h01, Z, OK);
    xfer(T2, spmh_pkg::OP_BUF_SAVE, 8'h03, Z, OK);
    xfer(T1, spmh_pkg::OP_SEG_LAUNCH, 8'h03, Z, OK);
    repeat (20) @(posedge ref_clk);
    #1;
    `CHK(prog_running, 1'b1)
    xfer(T2, spmh_pkg::OP_PROG_HALT, 8'h01, Z, OK);
    // Short segment ends at its blank line
    xfer(T1, spmh_pkg::OP_SEG_LAUNCH, 8'h02, Z, OK);
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK(prog_running, 1'b0)
    xfer(T2, spmh_pkg::OP_PARAM_READ, spmh_pkg::OPR_STATUS_WORD, Z, DS);
    // Out-of-range segment and unknown opcode
    xfer(T1, spmh_pkg::OP_SEG_LAUNCH, 8'h0D, Z, spmh_pkg::STAT_BAD_REQ);
    xfer(T2, 8'h55, 8'h00, Z, spmh_pkg::STAT_BAD_REQ);
    // Unknown message type carrying a halt opcode must change nothing
    xfer(8'h03, spmh_pkg::OP_PROG_HALT, 8'h00, Z, spmh_pkg::STAT_BAD_REQ);
    `CHK(n_halt, 3)
    `CHK(prog_running, 1'b0)
    // Velocity waits for the next move
    xfer(T2, spmh_pkg::OP_PARAM_WRITE, spmh_pkg::OPR_VELOCITY, 16'h0123, OK);
    `CHK(velocity_param, Z)
    pulse(1'b1);
    `CHK(velocity_param, 16'h0123)
    // Maintenance port: hold, close, refuse, reopen, hold
    pulse(1'b0);
    `CHK(held, 1'b1)
    xfer(T2, spmh_pkg::OP_MAINT_PORT, spmh_pkg::OPR_PORT_RESET, Z, OK);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK({closed, held}, 2'b10)
    pulse(1'b0);
    `CHK(held, 1'b0)
    xfer(T2, spmh_pkg::OP_MAINT_PORT, spmh_pkg::OPR_PORT_OPEN, Z, OK);
    pulse(1'b0);
    `CHK({closed, held}, 2'b01)
    end_sim();
  end
endmodule // test_spmh_handler
